// ---- pkg/adc_cfg_params.svh ----
/*
 Constants of the acquisition configuration register: width, default word,
 field positions and serial frame counts.
 Assumes inclusion by bare name from package and design files.
*/
`ifndef ADC_CFG_PARAMS_SVH
`define ADC_CFG_PARAMS_SVH

`define CFG_WIDTH          16
`define CFG_DEFAULT        16'h8FCF
`define CFG_UPDATE_BIT     15
`define CFG_CHAN_MSB       14
`define CFG_CHAN_LSB       12
`define CFG_COMMON_BIT     11
`define CFG_SPARE_BIT      10
`define CFG_GAIN_MSB       9
`define CFG_GAIN_LSB       7
`define CFG_SOURCE_BIT     6
`define CFG_SEQ_MSB        5
`define CFG_SEQ_LSB        4
`define CFG_TEMP_BIT       3
`define CFG_VREF_BIT       2
`define CFG_CMS_BIT        1
`define CFG_PHASE_BIT      0
`define GAIN_CODE_UNUSED   3'h6
`define WRITE_EDGES        5'h10
`define READ_FRAME_BITS    32
`define DUMMY_CONVERSIONS  2'h2
`define SYNC_RESET_IDLE    5'h05

`endif

// ---- pkg/adc_cfg_pkg.sv ----
/*
 Types shared by the configuration register load logic.
 Assumes the constants header is on the include path.
*/
`include "adc_cfg_params.svh"

package adc_cfg_pkg;

   // One configuration word
   typedef logic [`CFG_WIDTH-1:0] cfg_word_t;

   // Serial write capture states, Gray along idle, shift, done
   typedef enum logic [1:0]
   {
      SER_IDLE  = 2'h0,
      SER_SHIFT = 2'h1,
      SER_DONE  = 2'h3
   } ser_state_e;

endpackage

// ---- pkg/cfg_link_if.sv ----
/*
 Interface between the serial front end and the configuration stage.
 Assumes both ends run on clk_sys.
*/
`timescale 1ns/1ns

interface cfg_link_if;
   import adc_cfg_pkg::*;

   logic      word_valid;    // Full 16-bit word captured, one cycle
   cfg_word_t word;          // Captured word
   logic      eoc;           // End of conversion, one cycle
   logic      load_default;  // Reset state, level
   cfg_word_t active;        // Configuration in force
   cfg_word_t readback;      // Configuration of the conversion just ended
   logic      pending;       // A committed-at-next-EOC word is waiting

   modport ctrl
   (
      output word_valid,
      output word,
      output eoc,
      output load_default,
      input  active,
      input  readback,
      input  pending
   );

   modport stage
   (
      input  word_valid,
      input  word,
      input  eoc,
      input  load_default,
      output active,
      output readback,
      output pending
   );

endinterface

// ---- rtl/config_stage.sv ----
/*
 Shadow, active and readback stages of the configuration word.
 Assumes word_valid and eoc are single-cycle pulses on clk_sys.
*/
`timescale 1ns/1ns
`include "adc_cfg_params.svh"

module config_stage
(
   input wire logic clk_sys,
   input wire logic rst_n,
   cfg_link_if.stage link
);
   import adc_cfg_pkg::*;

   cfg_word_t shadow;
   logic      shadow_full;

   ////////////////////////////////////////////////////////////////////////
   // Shadow stage: only whole words with the update bit set are kept
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shadow      <= `CFG_DEFAULT;
         shadow_full <= 1'b0;
      end
      else if (link.load_default)
      begin
         shadow_full <= 1'b0;
      end
      else if (link.word_valid && link.word[`CFG_UPDATE_BIT]) // see RULE9
      begin
         shadow      <= link.word;  // see RULE17
         shadow_full <= 1'b1;       // Set wins over the EOC clear
      end
      else if (link.eoc)
      begin
         shadow_full <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Active and readback stages move only on end of conversion or default load
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link.active   <= `CFG_DEFAULT;
         link.readback <= `CFG_DEFAULT;
      end
      else if (link.load_default)
      begin
         link.active   <= `CFG_DEFAULT;  // see RULE5
         link.readback <= `CFG_DEFAULT;
      end
      else if (link.eoc)
      begin
         link.readback <= link.active;  // see RULE4
         if (shadow_full)
         begin
            link.active <= shadow;      // see RULE3
         end
      end
   end

   assign link.pending = shadow_full;

endmodule // config_stage

// ---- rtl/acquisition_config_load.sv ----
/*
 Configuration register load of a multichannel SAR acquisition device:
 serial capture of the write word, two-stage commit at end of conversion,
 readback shifting and decode of the active fields.
 Assumes serial pins are asynchronous to clk_sys and much slower than it;
 eoc and conv_result come from conversion logic on clk_sys.
*/
// Behaviour
// RULE1: All options live in one 16-bit configuration word written over serial.
// RULE2: Host shifts the word on the first 16 rising serial clock edges.
// RULE3: A captured word becomes active only at the next end of conversion.
// RULE4: Word written in frame n governs conversion n+2; readback lags two.
// RULE5: Leaving the reset state loads the default word into the configuration.
// RULE6: Leaving power-down keeps the user word; host runs two dummy conversions.
// RULE7: Default word is 8FCF hexadecimal.
// RULE8: Field layout from update bit 15 down to output phase bit 0.
// RULE9: Update bit 0 keeps current configuration; 1 replaces it.
// RULE10: Bits 14:12 select one of eight inputs in plain binary.
// RULE11: Bit 11 sets main input referencing; auxiliary pair never uses common.
// RULE12: Default selects first input, common, widest gain, mux, reference on.
// RULE13: The spare bit 10 has no effect on behaviour.
// RULE14: Common bit 0 pairs inputs differentially; 1 references each to common.
// RULE15: Gain codes 000 to 101 and 111 select ranges; 110 is unused.
// RULE16: Source bit 0 selects auxiliary pair; 1 the front-end channel.
// RULE17: Captured word waits in a shadow stage; partial frames change nothing.
`timescale 1ns/1ns
`include "adc_cfg_params.svh"

module acquisition_config_load
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic                  cs_n,
   input  wire logic                  sck,
   input  wire logic                  sdi,
   output logic                       sdo,
   output logic                       sdo_oe,
   input  wire logic                  device_reset,
   input  wire logic                  power_down_input,
   input  wire logic                  eoc,
   input  wire adc_cfg_pkg::cfg_word_t conv_result,
   output logic [2:0]                 channel_select,
   output logic                       shared_return_select,
   output logic [2:0]                 gain_range_select,
   output logic                       gain_range_valid,
   output logic                       input_source_select,
   output logic [1:0]                 scan_sequencer_mode,
   output logic                       thermal_sensor_disable,
   output logic                       internal_vref_enable,
   output logic                       conversion_timing_mode,
   output logic                       output_phase_select,
   output logic                       aux_active,
   output logic [2:0]                 pos_input,
   output logic [2:0]                 neg_input,
   output logic                       neg_is_common,
   output logic                       user_cfg_settled
);
   import adc_cfg_pkg::*;

   // Field pick of a 3-bit field, used for channel and gain
   function automatic logic [2:0] field3(input cfg_word_t w, input int lsb);
      field3 = 3'(w >> lsb);
   endfunction

   // Gain code 110 selects no range
   function automatic logic gain_ok(input logic [2:0] code);
      gain_ok = (code != `GAIN_CODE_UNUSED);
   endfunction

   cfg_link_if link ();

   logic [4:0]             sync1;
   logic [4:0]             sync2;
   logic                   sck_prev;
   logic                   cs_prev;
   logic                   rst_prev;
   logic                   pd_prev;
   logic                   sck_rise;
   logic                   sck_fall;
   logic                   cs_fall;
   logic                   cs_rise;
   logic                   cs_low;
   logic                   in_reset;
   logic                   in_pd;
   logic                   pd_leave;
   ser_state_e             ser_state;
   ser_state_e             next_ser_state;
   logic [4:0]             rx_count;
   cfg_word_t              rx_shift;
   cfg_word_t              result_hold;
   logic [`READ_FRAME_BITS-1:0] tx_shift;
   logic                   tx_hold_first;
   logic [1:0]             dummy_count;
   cfg_word_t              act;

   ////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers: cs_n, sck, sdi, device_reset, power-down
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1 <= `SYNC_RESET_IDLE;
         sync2 <= `SYNC_RESET_IDLE;
      end
      else
      begin
         sync1 <= {power_down_input, device_reset, sdi, sck, cs_n};
         sync2 <= sync1;
      end
   end

   // Previous synchronised values for edge detection
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cs_prev  <= 1'b1;
         sck_prev <= 1'b0;
         rst_prev <= 1'b1;
         pd_prev  <= 1'b0;
      end
      else
      begin
         cs_prev  <= sync2[0];
         sck_prev <= sync2[1];
         rst_prev <= sync2[3];
         pd_prev  <= sync2[4];
      end
   end

   // Edges and levels of the synchronised pins
   assign cs_low   = ~sync2[0];
   assign cs_fall  = cs_prev & ~sync2[0];
   assign cs_rise  = ~cs_prev & sync2[0];
   assign sck_rise = ~sck_prev & sync2[1] & cs_low;
   assign sck_fall = sck_prev & ~sync2[1] & cs_low;
   assign in_reset = sync2[3] | rst_prev;   // Held until one cycle after release
   assign in_pd    = sync2[4];
   assign pd_leave = pd_prev & ~sync2[4];

   ////////////////////////////////////////////////////////////////////////
   // Write capture state: a frame starts at chip select, ends at 16 edges
   always_comb
   begin
      next_ser_state = ser_state;
      case (ser_state)
         SER_IDLE:
         begin
            if (cs_fall)
            begin
               next_ser_state = SER_SHIFT;
            end
         end
         SER_SHIFT:
         begin
            if (cs_rise)
            begin
               next_ser_state = SER_IDLE;  // Partial word dropped, see RULE17
            end
            else if (sck_rise && rx_count == `WRITE_EDGES - 5'h01)
            begin
               next_ser_state = SER_DONE;
            end
         end
         SER_DONE:
         begin
            if (cs_rise)
            begin
               next_ser_state = SER_IDLE;  // Readback edges write nothing
            end
         end
         default:
         begin
            next_ser_state = SER_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ser_state <= SER_IDLE;
      end
      else if (in_reset)
      begin
         ser_state <= SER_IDLE;
      end
      else
      begin
         ser_state <= next_ser_state;
      end
   end

   // Shift sdi in MSB first on rising serial clock edges
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_count <= 5'h00;
         rx_shift <= `CFG_WIDTH'h0;
      end
      else if (ser_state != SER_SHIFT)
      begin
         rx_count <= 5'h00;
      end
      else if (sck_rise)
      begin
         rx_count <= rx_count + 5'h01;             // see RULE2
         rx_shift <= {rx_shift[`CFG_WIDTH-2:0], sync2[2]};  // see RULE1
      end
   end

   // Whole word handed to the stage in the cycle after the 16th edge
   assign link.word_valid   = (ser_state == SER_DONE) && (rx_count == `WRITE_EDGES);
   assign link.word         = rx_shift;
   assign link.eoc          = eoc & ~in_reset & ~in_pd;
   assign link.load_default = in_reset;  // see RULE5

   // Power-down leaves the stages untouched, no default load
   config_stage stage_u
   (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .link    (link)
   );

   assign act = link.active;

   ////////////////////////////////////////////////////////////////////////
   // Conversion result held at end of conversion for readback
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         result_hold <= `CFG_WIDTH'h0;
      end
      else if (link.eoc)
      begin
         result_hold <= conv_result;
      end
   end

   // Readback: result then its configuration word, repeating on falling edges
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_shift      <= '0;
         tx_hold_first <= 1'b0;
      end
      else if (cs_fall)
      begin
         tx_shift      <= {result_hold, link.readback};  // see RULE4
         tx_hold_first <= act[`CFG_PHASE_BIT];
      end
      else if (sck_fall)
      begin
         if (tx_hold_first)
         begin
            tx_hold_first <= 1'b0;  // Phase 1 repeats the MSB once
         end
         else
         begin
            tx_shift <= {tx_shift[`READ_FRAME_BITS-2:0], tx_shift[`READ_FRAME_BITS-1]};
         end
      end
   end

   // Serial data out, driven only while selected
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sdo_oe <= 1'b0;
      end
      else
      begin
         sdo_oe <= cs_low;
      end
   end

   assign sdo = tx_shift[`READ_FRAME_BITS-1];

   ////////////////////////////////////////////////////////////////////////
   // Conversions seen since leaving power-down
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dummy_count <= `DUMMY_CONVERSIONS;
      end
      else if (in_reset)
      begin
         dummy_count <= `DUMMY_CONVERSIONS;  // Default word already in force
      end
      else if (pd_leave)
      begin
         dummy_count <= 2'h0;                // see RULE6
      end
      else if (link.eoc && dummy_count != `DUMMY_CONVERSIONS)
      begin
         dummy_count <= dummy_count + 2'h1;
      end
   end

   assign user_cfg_settled = (dummy_count == `DUMMY_CONVERSIONS);

   ////////////////////////////////////////////////////////////////////////
   // Field decode of the active word; spare bit is never looked at
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         channel_select         <= 3'(`CFG_DEFAULT >> `CFG_CHAN_LSB);  // see RULE7
         shared_return_select   <= 1'b1;
         gain_range_select      <= 3'(`CFG_DEFAULT >> `CFG_GAIN_LSB);  // see RULE7
         gain_range_valid       <= 1'b1;
         input_source_select    <= 1'b1;
         scan_sequencer_mode    <= 2'h0;
         thermal_sensor_disable <= 1'b1;
         internal_vref_enable   <= 1'b1;
         conversion_timing_mode <= 1'b1;
         output_phase_select    <= 1'b1;
      end
      else
      begin
         channel_select         <= field3(act, `CFG_CHAN_LSB);  // see RULE10
         shared_return_select   <= act[`CFG_COMMON_BIT];        // see RULE8
         gain_range_select      <= field3(act, `CFG_GAIN_LSB);  // see RULE15
         gain_range_valid       <= gain_ok(field3(act, `CFG_GAIN_LSB));  // see RULE15
         input_source_select    <= act[`CFG_SOURCE_BIT];        // see RULE16
         scan_sequencer_mode    <= act[`CFG_SEQ_MSB:`CFG_SEQ_LSB];
         thermal_sensor_disable <= act[`CFG_TEMP_BIT];          // see RULE12
         internal_vref_enable   <= act[`CFG_VREF_BIT];
         conversion_timing_mode <= act[`CFG_CMS_BIT];
         output_phase_select    <= act[`CFG_PHASE_BIT];         // see RULE8
      end
   end

   // Input routing: auxiliary pair, differential pairs or common return
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aux_active    <= 1'b0;
         pos_input     <= 3'h0;
         neg_input     <= 3'h0;
         neg_is_common <= 1'b1;
      end
      else if (!act[`CFG_SOURCE_BIT])
      begin
         aux_active    <= 1'b1;  // see RULE16
         pos_input     <= 3'h0;
         neg_input     <= 3'h0;
         neg_is_common <= 1'b0;  // see RULE11
      end
      else if (act[`CFG_COMMON_BIT])
      begin
         aux_active    <= 1'b0;
         pos_input     <= field3(act, `CFG_CHAN_LSB);
         neg_input     <= 3'h0;
         neg_is_common <= 1'b1;  // see RULE14
      end
      else
      begin
         aux_active    <= 1'b0;
         pos_input     <= {field3(act, `CFG_CHAN_LSB) & 3'h6};  // see RULE14
         neg_input     <= {field3(act, `CFG_CHAN_LSB) | 3'h1};
         neg_is_common <= 1'b0;
      end
   end

   // Spare bit 10 is stored in the word and reaches only sdo through the readback, see RULE13

endmodule // acquisition_config_load

// ---- verif/acquisition_config_properties.sv ----
/*
 Checker of the configuration load ports: serial enable, commit timing,
 routing decode, default load and power-down settling.
 Assumes it is bound to acquisition_config_load and sees its ports only.
*/
`timescale 1ns/1ns

module acquisition_config_checker
(
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic       cs_n,
   input wire logic       device_reset,
   input wire logic       power_down_input,
   input wire logic       eoc,
   input wire logic       sdo_oe,
   input wire logic [2:0] channel_select,
   input wire logic       shared_return_select,
   input wire logic [2:0] gain_range_select,
   input wire logic       gain_range_valid,
   input wire logic       input_source_select,
   input wire logic       aux_active,
   input wire logic [2:0] pos_input,
   input wire logic [2:0] neg_input,
   input wire logic       neg_is_common,
   input wire logic       user_cfg_settled
);
   logic [3:0] rst_age;
   wire  [7:0] fld = {channel_select, shared_return_select, gain_range_select,
                      input_source_select};

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////////
   // Cycles since the device reset pin was last high, saturating
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
         rst_age <= 4'h0;
      else if (device_reset)
         rst_age <= 4'h0;
      else if (rst_age != 4'hF)
         rst_age <= rst_age + 4'h1;

   ////////////////////////////////////////////////////////////////////////////////
   // Port relations
   chk_oe_on: assert property ($fell(cs_n) |-> ##[1:5] sdo_oe)
      else $error("read enable not raised after select");
   chk_oe_off: assert property ($rose(cs_n) |-> ##[1:5] !sdo_oe)
      else $error("read enable not dropped after deselect");
   chk_commit_eoc: assert property ($changed(fld) |-> $past(eoc, 2) || $past(eoc, 3)
      || rst_age < 4'h8)
      else $error("configuration changed without end of conversion");
   chk_gain_code: assert property (gain_range_valid == (gain_range_select != 3'h6))
      else $error("gain valid flag wrong");
   chk_aux_source: assert property (aux_active == !input_source_select)
      else $error("auxiliary flag disagrees with source bit");
   chk_aux_route: assert property (aux_active |-> !neg_is_common && pos_input == 3'h0
      && neg_input == 3'h0)
      else $error("auxiliary pair routed to common");
   chk_common_ref: assert property (input_source_select && shared_return_select |->
      neg_is_common && pos_input == channel_select && neg_input == 3'h0)
      else $error("common referencing wrong");
   chk_pair_ref: assert property (input_source_select && !shared_return_select |->
      !neg_is_common && pos_input == {channel_select[2:1], 1'h0}
      && neg_input == {channel_select[2:1], 1'h1})
      else $error("differential pairing wrong");
   chk_default_load: assert property ($fell(device_reset) |-> ##6 fld == 8'h1F)
      else $error("default word not loaded after device reset");
   chk_pd_settle: assert property ($fell(power_down_input) |-> ##[1:6] !user_cfg_settled)
      else $error("settled flag not dropped after power-down");

   // Main scenarios reached
   cover property ($fell(cs_n));
   cover property (eoc ##2 $changed(fld));
   cover property ($fell(power_down_input));
endmodule // acquisition_config_checker

bind acquisition_config_load acquisition_config_checker u_checker
(
   .clk_sys, .rst_n, .cs_n, .device_reset, .power_down_input, .eoc, .sdo_oe,
   .channel_select, .shared_return_select, .gain_range_select, .gain_range_valid,
   .input_source_select, .aux_active, .pos_input, .neg_input, .neg_is_common,
   .user_cfg_settled
);

// ---- verif/host_model.sv ----
/*
 Host side of the serial port: frames of chip select, clock and write data.
 Assumes clk_sys paces the link; one serial clock period is eight clk_sys cycles.
*/
`timescale 1ns/1ns

module host_model
(
   input  wire logic clk_sys,
   input  wire logic sdo,
   output logic      cs_n,
   output logic      sck,
   output logic      sdi
);
   import adc_cfg_pkg::*;

   // Idle pins, serial clock stands low outside frames
   initial
   begin
      cs_n = 1'h1;
      sck  = 1'h0;
      sdi  = 1'h0;
   end

   // Unused data line toggles so a stale bit is never taken for data
   always @(posedge clk_sys)
      if (cs_n)
         #2 sdi = ~sdi;

   task automatic tick(input int c);
      repeat (c) @(posedge clk_sys);
      #2;
   endtask

   // One frame of n rising edges; read bit sampled just before each fall
   task automatic xfer(input cfg_word_t wr, input int n, output logic [31:0] rd);
      rd = 32'h0;
      tick(1);
      cs_n = 1'h0;
      tick(4);
      for (int k = 0; k < n; k++)
      begin
         sdi = (k < 16) ? wr[15 - k] : ~sdi;
         tick(4);
         sck = 1'h1;
         tick(4);
         rd[31 - k] = sdo;
         sck = 1'h0;
      end
      tick(4);
      cs_n = 1'h1;
      tick(6);
   endtask
endmodule // host_model

// ---- verif/tb_top.sv ----
/*
 Self-checking bench of the configuration register load: a table of words,
 then partial frame, device reset and power-down cases.
 Assumes the host model drives the serial pins and the checker is bound.
*/
`timescale 1ns/1ns

module tb_top;
   import adc_cfg_pkg::*;

   typedef struct packed
   {
      cfg_word_t  w;
      cfg_word_t  e;
      logic [8:0] r;
   } row_s;

   logic       clk_sys, rst_n, device_reset, power_down_input, eoc;
   logic       cs_n, sck, sdi, sdo, sdo_oe, pend, seen;
   logic [2:0] channel_select, gain_range_select, pos_input, neg_input;
   logic [1:0] scan_sequencer_mode;
   logic       shared_return_select, gain_range_valid, input_source_select;
   logic       thermal_sensor_disable, internal_vref_enable, conversion_timing_mode;
   logic       output_phase_select, aux_active, neg_is_common, user_cfg_settled;
   cfg_word_t  conv_result, act, rb, res, pw;
   int         fail_count, comparisons;
   int         cycles = 0;
   wire [13:0] flds = {channel_select, shared_return_select, gain_range_select,
                       input_source_select, scan_sequencer_mode, thermal_sensor_disable,
                       internal_vref_enable, conversion_timing_mode, output_phase_select};
   wire [8:0]  rt = {aux_active, pos_input, neg_input, neg_is_common, gain_range_valid};

   // Written word, effective word, routing {aux, pos, neg, common, gain valid}
   row_s rows [9] = '{'{16'h8440, 16'h8440, 9'h005}, '{16'h98DA, 16'h98DA, 9'h023},
                      '{16'hA125, 16'hA125, 9'h101}, '{16'hB5FE, 16'hB5FE, 9'h04D},
                      '{16'hCA40, 16'hCA40, 9'h083}, '{16'hD2D1, 16'hD2D1, 9'h095},
                      '{16'hEF6C, 16'hEF6C, 9'h0C2}, '{16'hF3F3, 16'hF3F3, 9'h0DD},
                      '{16'h0123, 16'hF3F3, 9'h0DD}};

   acquisition_config_load u_acquisition_config_load
   (
      .clk_sys, .rst_n, .cs_n, .sck, .sdi, .sdo, .sdo_oe, .device_reset, .power_down_input,
      .eoc, .conv_result, .channel_select, .shared_return_select, .gain_range_select,
      .gain_range_valid, .input_source_select, .scan_sequencer_mode, .thermal_sensor_disable,
      .internal_vref_enable, .conversion_timing_mode, .output_phase_select, .aux_active,
      .pos_input, .neg_input, .neg_is_common, .user_cfg_settled
   );

   host_model u_host_model (.clk_sys, .sdo, .cs_n, .sck, .sdi);

   ////////////////////////////////////////////////////////////////////////////////
   // Clock
   initial
   begin
      clk_sys = 1'h0;
      forever
         #25 clk_sys = ~clk_sys;
   end

   // Cycle ceiling cuts a hung run short
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         fail_count++;
         conclude();
      end
   end

   task automatic tick(input int c);
      repeat (c) @(posedge clk_sys);
      #2;
   endtask

   task automatic tally(input bit bad, input string what);
      comparisons++;
      if (bad)
      begin
         fail_count++;
         $display("MISMATCH at %0t: %s differs", $time, what);
      end
   endtask

   task automatic cmp_fld(input cfg_word_t e);
      tally(flds !== {e[14:11], e[9:0]}, "fields");
   endtask

   task automatic cmp_rt(input logic [8:0] e);
      tally(rt !== e, "routing");
   endtask

   task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
      tally(g !== e, "read frame");
   endtask

   task automatic cmp_bit(input logic g, input logic e);
      tally(g !== e, "flag");
   endtask

   // End of conversion pulse; bench model commits the pending word
   task automatic conv(input cfg_word_t r);
      conv_result = r;
      eoc = 1'h1;
      tick(1);
      eoc = 1'h0;
      rb = act;
      if (pend)
         act = pw;
      pend = 1'h0;
      res = r;
      seen = 1'h1;
      tick(3);
   endtask

   // Frame writes w and reads result then readback; phase bit repeats the first bit
   task automatic frame(input cfg_word_t w, input int n);
      logic [31:0] rd;
      logic [31:0] ex;
      ex = {res, rb};
      if (act[0])
         ex = {ex[31], ex[31:1]};
      u_host_model.xfer(w, n, rd);
      if (seen && n == 32)
         cmp_rd(rd, ex);
      if (n >= 16 && w[15])
      begin
         pend = 1'h1;
         pw = w;
      end
      cmp_fld(act);
   endtask

   task automatic conclude();
      if (fail_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {rst_n, eoc, device_reset, power_down_input, pend, seen} = 6'h00;
      {conv_result, res, pw} = 48'h0;
      act = 16'h8FCF;
      rb = 16'h8FCF;
      fail_count = 0;
      comparisons = 0;
      tick(8);
      rst_n = 1'h1;
      tick(4);
      cmp_fld(16'h8FCF);
      cmp_rt(9'h003);
      cmp_bit(user_cfg_settled, 1'h1);
      cmp_bit(sdo_oe, 1'h0);
      for (int i = 0; i < 9; i++)
      begin
         frame(rows[i].w, 32);
         conv(~rows[i].w);
         cmp_fld(rows[i].e);
         cmp_rt(rows[i].r);
      end
      // Partial frame leaves the configuration alone
      frame(16'h8440, 8);
      conv(16'h5A5A);
      cmp_fld(16'hF3F3);
      // Device reset drops the pending word and loads the default
      frame(16'hA125, 32);
      device_reset = 1'h1;
      tick(6);
      device_reset = 1'h0;
      tick(8);
      act = 16'h8FCF;
      rb = 16'h8FCF;
      pend = 1'h0;
      cmp_fld(16'h8FCF);
      cmp_rt(9'h003);
      conv(16'hC3C3);
      cmp_fld(16'h8FCF);
      // Power-down keeps the user word; two dummy conversions settle it
      frame(16'hB5FE, 32);
      conv(16'h0F0F);
      power_down_input = 1'h1;
      tick(6);
      power_down_input = 1'h0;
      tick(6);
      cmp_fld(16'hB5FE);
      cmp_bit(user_cfg_settled, 1'h0);
      conv(16'h1111);
      cmp_bit(user_cfg_settled, 1'h0);
      conv(16'h2222);
      cmp_bit(user_cfg_settled, 1'h1);
      frame(16'h0000, 32);
      conclude();
   end
endmodule // tb_top
